// ===== core/mgpc_pkg.sv
// package of constants for the general pin port control block
package mgpc_pkg;
	localparam int unsigned     PIN_COUNT      = 3;
	localparam int unsigned     RESET_PIN_IDX  = 2;
	localparam logic [2:0]      DIR_RESET_VAL  = 3'h0;
	localparam logic [2:0]      OUT_RESET_VAL  = 3'h0;
	localparam logic [2:0]      IN_RESET_VAL   = 3'h0;
	localparam logic            EN_RESET_VAL   = 1'h0;
	localparam logic            FAULT_RESET_VAL = 1'h0;
endpackage

// ===== core/mgpc_port.sv
// three-pin general purpose port with per-pin direction and port enable
// Summary of operation
// - three two-way pins, each with own output driver and input receiver
// - after reset every output driver is off, pins float
// - a pin drives only when port enabled and its own direction is output; under debug control the reset pin drives by processor reset, not direction
// - disabling the port tri-states every pin at once, any direction
// - port usable only while serial test and serial peripheral functions are off
// - third pin is the active-low processor reset output
`timescale 1ns/1ps
`default_nettype none
module mgpc_port
	import mgpc_pkg::*;
(
	input  wire logic                 core_clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 host_pin_port_en_i,
	input  wire logic                 jtag_active_i,
	input  wire logic                 spi_active_i,
	input  wire logic [PIN_COUNT-1:0] pin_dir_out_i,
	input  wire logic [PIN_COUNT-1:0] pin_out_val_i,
	input  wire logic                 processor_system_reset_n_i,
	input  wire logic                 reset_ctrl_by_debug_i,
	input  wire logic [PIN_COUNT-1:0] pin_in_i,
	output logic      [PIN_COUNT-1:0] pin_out_o,
	output logic      [PIN_COUNT-1:0] pin_oe_o,
	output logic      [PIN_COUNT-1:0] pin_rd_val_o,
	output logic                      host_pin_port_active_o,
	output logic                      port_conflict_o
);
	logic                      port_ok;
	logic                      dbg_owns_rst;
	logic                      act_ff;
	logic                      flt_ff;
	logic                      nxt_act;
	logic                      nxt_flt;
	wire logic [PIN_COUNT-1:0] out_bits;
	wire logic [PIN_COUNT-1:0] oe_bits;
	wire logic [PIN_COUNT-1:0] rd_bits;

	// port acceptance group
	// enabling while a shared function runs is refused and the pins stay off
	always_comb begin
		port_ok      = host_pin_port_en_i & ~jtag_active_i & ~spi_active_i;

		// debug ownership of the reset pin still needs the port accepted
		dbg_owns_rst = port_ok & reset_ctrl_by_debug_i;

		nxt_act      = port_ok;

		// the flag tells the host why its enable had no effect
		nxt_flt      = host_pin_port_en_i & (jtag_active_i | spi_active_i);
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			act_ff <= EN_RESET_VAL;
			flt_ff <= FAULT_RESET_VAL;
		end else begin
			act_ff <= nxt_act;
			flt_ff <= nxt_flt;
		end
	end

	// one slice per pin; only the reset pin slice differs
	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
		logic sync1_ff;
		logic sync2_ff;
		logic nxt_sync1;
		logic nxt_sync2;
		logic oe_ff;
		logic nxt_oe;
		logic out_ff;
		logic nxt_out;
		logic rd_ff;
		logic nxt_rd;

		// synchroniser group
		// the receiver sees the board, so two stages before any logic reads it
		always_comb begin
			nxt_sync1 = pin_in_i[i];
			nxt_sync2 = sync1_ff;
		end

		always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				sync1_ff <= IN_RESET_VAL[i];
				sync2_ff <= IN_RESET_VAL[i];
			end else begin
				sync1_ff <= nxt_sync1;
				sync2_ff <= nxt_sync2;
			end
		end

		// output enable group
		if (i == RESET_PIN_IDX) begin : g_rst_oe
			always_comb begin
				nxt_oe = DIR_RESET_VAL[i];

				if (port_ok) begin
					nxt_oe = pin_dir_out_i[i];
				end

				// released means float: open-drain style, so a board reset button can share the line
				if (dbg_owns_rst) begin
					nxt_oe = ~processor_system_reset_n_i;
				end

				// disable wins over everything, in the same registered cycle
				if (!port_ok) begin
					nxt_oe = DIR_RESET_VAL[i];
				end
			end
		end else begin : g_gen_oe
			always_comb begin
				nxt_oe = DIR_RESET_VAL[i];

				if (port_ok) begin
					nxt_oe = pin_dir_out_i[i];
				end

				if (!port_ok) begin
					nxt_oe = DIR_RESET_VAL[i];
				end
			end
		end

		always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				oe_ff <= DIR_RESET_VAL[i];
			end else begin
				oe_ff <= nxt_oe;
			end
		end

		// drive value group
		// the value follows the host even for an input pin; the enable alone decides the pin
		if (i == RESET_PIN_IDX) begin : g_rst_val
			always_comb begin
				nxt_out = OUT_RESET_VAL[i];

				if (port_ok) begin
					nxt_out = pin_out_val_i[i];
				end

				// the reset line is never driven high by the debug tools
				if (dbg_owns_rst) begin
					nxt_out = 1'h0;
				end
			end
		end else begin : g_gen_val
			always_comb begin
				nxt_out = OUT_RESET_VAL[i];

				if (port_ok) begin
					nxt_out = pin_out_val_i[i];
				end
			end
		end

		always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				out_ff <= OUT_RESET_VAL[i];
			end else begin
				out_ff <= nxt_out;
			end
		end

		// read-back group
		// a pin set to output, or a port turned off, keeps its last sampled level for the host
		always_comb begin
			nxt_rd = rd_ff;

			if (port_ok && !pin_dir_out_i[i]) begin
				nxt_rd = sync2_ff;
			end
		end

		always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				rd_ff <= IN_RESET_VAL[i];
			end else begin
				rd_ff <= nxt_rd;
			end
		end

		assign oe_bits[i]  = oe_ff;
		assign out_bits[i] = out_ff;
		assign rd_bits[i]  = rd_ff;
	end

	// every output is a flop of its own slice or of the port group
	always_comb begin
		pin_out_o              = out_bits;
		pin_oe_o               = oe_bits;
		pin_rd_val_o           = rd_bits;
		host_pin_port_active_o = act_ff;
		port_conflict_o        = flt_ff;
	end
endmodule // mgpc_port
`default_nettype wire

// ===== verif/mgpc_checker.sv
// assertions on the pin port ports
`timescale 1ns/1ps
`default_nettype none
module mgpc_chk(
	input wire logic       core_clk_i,
	input wire logic       sys_rst_i,
	input wire logic       host_pin_port_en_i,
	input wire logic       jtag_active_i,
	input wire logic       spi_active_i,
	input wire logic [2:0] pin_dir_out_i,
	input wire logic [2:0] pin_out_val_i,
	input wire logic       reset_ctrl_by_debug_i,
	input wire logic       processor_system_reset_n_i,
	input wire logic [2:0] pin_out_o,
	input wire logic [2:0] pin_rd_val_o,
	input wire logic [2:0] pin_oe_o,
	input wire logic       host_pin_port_active_o,
	input wire logic       port_conflict_o
);
	wire logic ok = host_pin_port_en_i & !jtag_active_i & !spi_active_i;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_oe_needs_port: assert property (|pin_oe_o |-> host_pin_port_active_o) else $error("oe without port");
	a_off_float: assert property (!host_pin_port_en_i |=> !pin_oe_o) else $error("oe after off");
	a_excl_off: assert property (jtag_active_i | spi_active_i |=> !host_pin_port_active_o) else $error("active");
	a_excl_flag: assert property (host_pin_port_en_i & !ok |=> port_conflict_o) else $error("no conflict");
	a_no_flag: assert property (!host_pin_port_en_i |=> !port_conflict_o) else $error("bad conflict");
	a_port_on: assert property (ok |=> host_pin_port_active_o) else $error("not active");
	a_dir_on: assert property (ok |=> pin_oe_o[1:0] == $past(pin_dir_out_i[1:0])) else $error("dir");
	a_rst_float: assert property ($fell(sys_rst_i) |-> !pin_oe_o) else $error("oe at reset");
	a_rst_pin_low: assert property (ok & reset_ctrl_by_debug_i & !processor_system_reset_n_i |=> pin_oe_o[2] & !pin_out_o[2]) else $error("reset pin not low");
	a_rst_pin_rel: assert property (ok & reset_ctrl_by_debug_i & processor_system_reset_n_i |=> !pin_oe_o[2]) else $error("reset pin not released");
	a_rd_hold: assert property (!ok |=> $stable(pin_rd_val_o)) else $error("read value moved");
	a_out_val: assert property (ok & !reset_ctrl_by_debug_i |=> pin_out_o == $past(pin_out_val_i)) else $error("drive value");
endmodule // mgpc_chk
bind mgpc_port mgpc_chk u_chk(.*);
`default_nettype wire

// ===== verif/mgpc_pins.sv
// pulled-up pin wires between the port and the target board
`timescale 1ns/1ps
`default_nettype none
module mgpc_pins(
	input  wire logic [2:0] oe_i,
	input  wire logic [2:0] out_i,
	input  wire logic [2:0] ext_i,
	output logic      [2:0] pin_o
);
	// ext_i at all ones stands for the pull-ups when nobody drives
	assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule // mgpc_pins
`default_nettype wire

// ===== verif/mgpc_port_tb.sv
// self-checking bench for the pin port
`timescale 1ns/1ps
`default_nettype none
module mgpc_port_tb;
	logic core_clk_i, sys_rst_i, host_pin_port_en_i, jtag_active_i, spi_active_i;
	logic reset_ctrl_by_debug_i, processor_system_reset_n_i, host_pin_port_active_o, port_conflict_o;
	logic [2:0] pin_dir_out_i, pin_out_val_i, pin_in_i, pin_out_o, pin_oe_o, pin_rd_val_o, ext;
	logic [10:0] ins;
	int failures = 0, n_checks = 0;
	// row: {en,jtag,spi,dbg,rst_n,dir,val} beside {active,conflict,oe,out}
	// under debug control the host leaves pin 2 as input and low
	// the test function drops only after the scan format handover, outside this block
	logic [18:0] rows[7] = '{{11'h459, 8'h99}, {11'h67f, 8'h40}, {11'h57f, 8'h40}, {11'h07f, 8'h00},
		{11'h480, 8'ha0}, {11'h4db, 8'h9b}, {11'h460, 8'ha0}};
	wire logic [7:0] outs = {host_pin_port_active_o, port_conflict_o, pin_oe_o, pin_out_o};
	assign {host_pin_port_en_i, jtag_active_i, spi_active_i, reset_ctrl_by_debug_i,
		processor_system_reset_n_i, pin_dir_out_i, pin_out_val_i} = ins;
	mgpc_port u_dut(.*);
	mgpc_pins u_pins(.oe_i(pin_oe_o), .out_i(pin_out_o), .ext_i(ext), .pin_o(pin_in_i));
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("BAD t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task summarize;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		core_clk_i = 0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	// generous: the whole run needs about 35 cycles, the limit allows 400
	initial begin
		#20000 failures++;
		summarize;
	end
	initial begin
		ins = 11'h000;
		ext = 3'h7;
		sys_rst_i = 1;
		repeat (11) @(posedge core_clk_i);
		#1 chk(outs, 8'h00);
		@(posedge core_clk_i) sys_rst_i <= 0;
		foreach (rows[i]) begin
			@(posedge core_clk_i) ins <= rows[i][18:8];
			@(posedge core_clk_i) #1 chk(outs, rows[i][7:0]);
			$display("row %0d done", i);
		end
		// all pins as inputs, target drives a pattern through the synchroniser
		@(posedge core_clk_i) ins <= 11'h440;
		ext <= 3'h5;
		repeat (5) @(posedge core_clk_i);
		#1 chk({5'h00, pin_rd_val_o}, 8'h05);
		@(posedge core_clk_i) sys_rst_i <= 1;
		#1 chk(outs, 8'h00);
		// release mid-run with the port still requested: pins stay off, port comes back
		@(posedge core_clk_i) sys_rst_i <= 0;
		@(posedge core_clk_i) #1 chk(outs, 8'h80);
		$display("read and reset done");
		summarize;
	end
endmodule // mgpc_port_tb
`default_nettype wire
